// ---- vr_pkg.sv ----
// Purpose: Shared constants and types for the regulator setpoint and latchoff block
// Assumes: 10 MHz master clock, byte-wide command registers on the two-wire bus
// Notes:   Counts are in master clock cycles
package vr_pkg;
	// Command codes
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_CODE   = 8'h21;
	localparam logic [7:0] CMD_REGULATOR_CONFIG_A    = 8'hD2;
	localparam logic [7:0] CMD_REGULATOR_CONFIG_B    = 8'hD3;
	localparam logic [7:0] CMD_OUTPUT_OFFSET_TRIM    = 8'hDB;
	localparam logic [7:0] CMD_OUTPUT_OFFSET_CAL     = 8'hDC;
	localparam logic [7:0] CMD_DROOP_CALIBRATION     = 8'hDE;
	localparam logic [7:0] CMD_DROOP_SETTING         = 8'hDF;
	localparam logic [7:0] CMD_PHASE1_BALANCE_GAIN   = 8'hE3;
	localparam logic [7:0] CMD_PHASE6_BALANCE_GAIN   = 8'hE8;
	localparam logic [7:0] CMD_PROTECTION_STATUS     = 8'h79;

	// Storage indices
	localparam logic [3:0] IDX_OUTPUT_VOLTAGE_CODE   = 4'h0;
	localparam logic [3:0] IDX_REGULATOR_CONFIG_A    = 4'h1;
	localparam logic [3:0] IDX_REGULATOR_CONFIG_B    = 4'h2;
	localparam logic [3:0] IDX_OUTPUT_OFFSET_TRIM    = 4'h3;
	localparam logic [3:0] IDX_OUTPUT_OFFSET_CAL     = 4'h4;
	localparam logic [3:0] IDX_DROOP_CALIBRATION     = 4'h5;
	localparam logic [3:0] IDX_DROOP_SETTING         = 4'h6;
	localparam logic [3:0] IDX_PHASE1_BALANCE_GAIN   = 4'h7;
	localparam int         NUM_REGS                  = 13;
	localparam int         NUM_PHASES                = 6;

	// Field positions
	localparam int         REGISTER_CODE_SELECT_BIT  = 3;
	localparam int         OFFSET_SIGN_BIT           = 5;

	// Values after reset
	localparam logic [7:0] RESET_GENERAL             = 8'h00;
	localparam logic [7:0] RESET_DROOP_SETTING       = 8'h10;
	localparam logic [7:0] RESET_DROOP_CALIBRATION   = 8'h10;
	localparam logic [7:0] RESET_PHASE_BALANCE_GAIN  = 8'h10;

	// Code limits
	localparam logic [6:0] DROOP_CENTER              = 7'h10;
	localparam logic [6:0] DROOP_MAX                 = 7'h1F;
	localparam logic [6:0] OFFSET_LIMIT              = 7'h1F;

	// Cycle counts
	localparam logic [11:0] STAGE_CYCLES             = 12'h040;
	localparam logic [2:0]  STAGE_LAST               = 3'h5;
	localparam logic [11:0] LATCHOFF_CYCLES          = 12'h800;

	// Bus target address; value is arbitrary
	localparam logic [6:0] TARGET_ADDRESS            = 7'h2A;

	typedef enum logic [4:0] {
		RUN_OFF         = 5'b00001,
		RUN_STARTUP     = 5'b00010,
		RUN_NORMAL      = 5'b00100,
		RUN_LATCH_TIMER = 5'b01000,
		RUN_LATCHED     = 5'b10000
	} run_state_type;

	typedef enum logic [6:0] {
		LINK_IDLE  = 7'b0000001,
		LINK_ADDR  = 7'b0000010,
		LINK_ACK   = 7'b0000100,
		LINK_CMD   = 7'b0001000,
		LINK_WDATA = 7'b0010000,
		LINK_RDATA = 7'b0100000,
		LINK_RACK  = 7'b1000000
	} link_state_type;

	typedef struct packed {
		logic       strobe;
		logic [7:0] cmd;
		logic [7:0] data;
	} reg_write_type;

	typedef struct packed {
		logic [7:0]                       voltage_id_code;
		logic [4:0]                       droop;
		logic [5:0]                       offset;
		logic [NUM_PHASES-1:0][4:0]       gains;
	} setpoint_type;
endpackage

// ---- serial_target.sv ----
// Purpose: Two-wire serial bus target that turns bus transfers into register accesses
// Assumes: scl and sda_in are already synchronous to clk; sda is open drain
// Notes:   Write: addr+W, command, data...; read: addr+W, command, restart, addr+R, data...
`timescale 1ns/1ps
module serial_target
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             scl,
	input  wire logic             sda_in,
	output logic                  sda_oe,
	output vr_pkg::reg_write_type wr,
	output logic [7:0]            rd_cmd,
	input  wire logic [7:0]       rd_data
);
	import vr_pkg::*;

	link_state_type state, next_state;
	logic [7:0]     bits, next_bits;
	logic [3:0]     cnt, next_cnt;
	logic           scl_q, sda_q, is_read, next_is_read, got_cmd, next_got_cmd, next_oe;
	logic [7:0]     cmd, next_cmd;
	reg_write_type  next_wr;
	logic           start, stop, rise, fall;

	assign start  = scl & scl_q & sda_q & ~sda_in;
	assign stop   = scl & scl_q & ~sda_q & sda_in;
	assign rise   = scl & ~scl_q;
	assign fall   = ~scl & scl_q;
	assign rd_cmd = cmd;

	always_comb
	begin
		next_state   = state;
		next_bits    = bits;
		next_cnt     = cnt;
		next_is_read = is_read;
		next_got_cmd = got_cmd;
		next_cmd     = cmd;
		next_oe      = sda_oe;
		next_wr      = '{strobe: 1'b0, cmd: cmd, data: bits};
		if (start)
		begin
			next_state   = LINK_ADDR;
			next_cnt     = 4'h0;
			next_oe      = 1'b0;
			next_got_cmd = 1'b0;
		end
		else if (stop)
		begin
			next_state = LINK_IDLE;
			next_oe    = 1'b0;
		end
		else
		begin
			case (state)
				LINK_ADDR, LINK_CMD, LINK_WDATA:
				begin
					if (rise)
					begin
						next_bits = {bits[6:0], sda_in};
						next_cnt  = cnt + 4'h1;
					end
					else if (fall && cnt == 4'h8)
					begin
						next_cnt   = 4'h0;
						next_oe    = 1'b1;
						next_state = LINK_ACK;
						if (state == LINK_ADDR)
						begin
							next_is_read = bits[0];
							if (bits[7:1] != TARGET_ADDRESS)
							begin
								// Not ours: stay off the wire until the next start
								next_oe    = 1'b0;
								next_state = LINK_IDLE;
							end
						end
						else if (state == LINK_CMD)
						begin
							next_cmd     = bits;
							next_got_cmd = 1'b1;
						end
						else
							next_wr = '{strobe: 1'b1, cmd: cmd, data: bits};
					end
				end
				LINK_ACK:
				begin
					if (fall)
					begin
						next_cnt = 4'h0;
						next_oe  = 1'b0;
						if (is_read)
						begin
							next_state = LINK_RDATA;
							next_bits  = rd_data;
							next_oe    = ~rd_data[7];
							next_cnt   = 4'h1;
						end
						else if (got_cmd)
							next_state = LINK_WDATA;
						else
							next_state = LINK_CMD;
					end
				end
				LINK_RDATA:
				begin
					if (fall)
					begin
						if (cnt == 4'h8)
						begin
							next_oe    = 1'b0;
							next_cnt   = 4'h0;
							next_state = LINK_RACK;
						end
						else
						begin
							next_oe   = ~bits[6];
							next_bits = {bits[6:0], 1'b0};
							next_cnt  = cnt + 4'h1;
						end
					end
				end
				LINK_RACK:
				begin
					// Controller ack asks for the same register again; nack ends the read
					if (rise)
						next_state = sda_in ? LINK_IDLE : LINK_ACK;
				end
				LINK_IDLE:
					next_oe = 1'b0;
				default:
				begin
					next_state = LINK_IDLE;
					next_oe    = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state   <= LINK_IDLE;
			bits    <= 8'h00;
			cnt     <= 4'h0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			is_read <= 1'b0;
			got_cmd <= 1'b0;
			cmd     <= 8'h00;
			sda_oe  <= 1'b0;
			wr      <= '0;
		end
		else
		begin
			state   <= next_state;
			bits    <= next_bits;
			cnt     <= next_cnt;
			scl_q   <= scl;
			sda_q   <= sda_in;
			is_read <= next_is_read;
			got_cmd <= next_got_cmd;
			cmd     <= next_cmd;
			sda_oe  <= next_oe;
			wr      <= next_wr;
		end
	end
endmodule

// ---- vr_setpoint_and_latchoff.sv ----
// Purpose: Over-current latchoff sequencing and serially programmed setpoints
// Assumes: enable, trip and comparator inputs are synchronous to clk
// Notes:   Analog loops consume the setpoint codes and the clamp and drive enables
`timescale 1ns/1ps
module vr_setpoint_and_latchoff
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         scl,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe,
	input  wire logic         enable,
	input  wire logic [7:0]   vid_pins,
	input  wire logic         current_limit_trip,
	input  wire logic         output_below_200mv,
	output logic              phase_drive_enable,
	output logic              latched,
	output logic [2:0]        startup_stage,
	output logic              secondary_limit_enable,
	output vr_pkg::setpoint_type setpoint
);
	import vr_pkg::*;

	logic                  rst_meta, rst_n;
	reg_write_type         wr;
	logic [7:0]            rd_cmd, rd_data;
	logic [7:0]            regs      [NUM_REGS];
	logic [7:0]            next_regs [NUM_REGS];
	run_state_type         state, next_state;
	logic [2:0]            next_stage;
	logic [11:0]           count, next_count;
	logic                  pending, next_pending;
	logic [NUM_PHASES-1:0][4:0] gain_codes;
	setpoint_type          next_setpoint;

	// Decoding shared by the write and read paths
	function automatic logic [4:0] reg_index(input logic [7:0] cmd);
		logic [4:0] r;
		r = 5'h00;
		case (cmd)
			CMD_OUTPUT_VOLTAGE_CODE: r = {1'b1, IDX_OUTPUT_VOLTAGE_CODE};
			CMD_REGULATOR_CONFIG_A:  r = {1'b1, IDX_REGULATOR_CONFIG_A};
			CMD_REGULATOR_CONFIG_B:  r = {1'b1, IDX_REGULATOR_CONFIG_B};
			CMD_OUTPUT_OFFSET_TRIM:  r = {1'b1, IDX_OUTPUT_OFFSET_TRIM};
			CMD_OUTPUT_OFFSET_CAL:   r = {1'b1, IDX_OUTPUT_OFFSET_CAL};
			CMD_DROOP_CALIBRATION:   r = {1'b1, IDX_DROOP_CALIBRATION};
			CMD_DROOP_SETTING:       r = {1'b1, IDX_DROOP_SETTING};
			default:
				if (cmd >= CMD_PHASE1_BALANCE_GAIN && cmd <= CMD_PHASE6_BALANCE_GAIN)
					r = {1'b1, IDX_PHASE1_BALANCE_GAIN + 4'(cmd - CMD_PHASE1_BALANCE_GAIN)};
		endcase
		return r;
	endfunction

	function automatic logic signed [7:0] sm_value(input logic [5:0] code);
		logic signed [7:0] m;
		m = signed'({3'h0, code[4:0]});
		return code[OFFSET_SIGN_BIT] ? -m : m;
	endfunction

	// Saturating sum of two sign-magnitude offsets, returned as sign-magnitude
	function automatic logic [5:0] offset_sum(input logic [5:0] a, input logic [5:0] b);
		logic signed [7:0] s;
		logic signed [7:0] lim;
		s   = sm_value(a) + sm_value(b);
		lim = signed'({1'b0, OFFSET_LIMIT});
		if (s > lim)
			s = lim;
		else if (s < -lim)
			s = -lim;
		return (s < 0) ? {1'b1, 5'(-s)} : {1'b0, 5'(s)};
	endfunction

	// Calibration trims the setting around its center; result kept inside 0..31
	function automatic logic [4:0] droop_code(input logic [4:0] set, input logic [4:0] cal);
		logic [6:0] s;
		s = {2'h0, set} + {2'h0, cal};
		if (s < DROOP_CENTER)
			s = 7'h00;
		else
			s = s - DROOP_CENTER;
		if (s > DROOP_MAX)
			s = DROOP_MAX;
		return s[4:0];
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	serial_target u_serial_target
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.scl     (scl),
		.sda_in  (sda_in),
		.sda_oe  (sda_oe),
		.wr      (wr),
		.rd_cmd  (rd_cmd),
		.rd_data (rd_data)
	);

	// Register file
	always_comb
	begin
		logic [4:0] wi;
		wi = reg_index(wr.cmd);
		for (int i = 0; i < NUM_REGS; i++)
			next_regs[i] = regs[i];
		if (wr.strobe && wi[4])
			next_regs[wi[3:0]] = wr.data;
	end

	always_comb
	begin
		logic [4:0] ri;
		ri = reg_index(rd_cmd);
		if (rd_cmd == CMD_PROTECTION_STATUS)
			rd_data = {pending, latched, 1'b0, state};
		else if (ri[4])
			rd_data = regs[ri[3:0]];
		else
			rd_data = 8'hFF;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs[i] <= (i >= int'(IDX_PHASE1_BALANCE_GAIN)) ? RESET_PHASE_BALANCE_GAIN
					: RESET_GENERAL;
			regs[IDX_DROOP_SETTING]     <= RESET_DROOP_SETTING;
			regs[IDX_DROOP_CALIBRATION] <= RESET_DROOP_CALIBRATION;
		end
		else
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs[i] <= next_regs[i];
		end
	end

	// Protection sequencer
	always_comb
	begin
		next_state   = state;
		next_stage   = startup_stage;
		next_count   = count;
		next_pending = pending;
		case (state)
			RUN_OFF:
				if (enable)
				begin
					next_state   = RUN_STARTUP;
					next_stage   = 3'h1;
					next_count   = 12'h000;
					next_pending = 1'b0;
				end
			RUN_STARTUP:
			begin
				// A trip here is remembered, not acted on, until the last stage ends
				next_pending = pending | current_limit_trip;
				next_count   = count + 12'h001;
				if (count == STAGE_CYCLES - 12'h001)
				begin
					next_count = 12'h000;
					if (startup_stage == STAGE_LAST)
						next_state = next_pending ? RUN_LATCH_TIMER : RUN_NORMAL;
					else
						next_stage = startup_stage + 3'h1;
				end
			end
			RUN_NORMAL:
				if (current_limit_trip)
				begin
					next_state = RUN_LATCH_TIMER;
					next_count = 12'h000;
				end
			RUN_LATCH_TIMER:
				if (!current_limit_trip)
				begin
					next_state   = RUN_NORMAL;
					next_pending = 1'b0;
				end
				else if (count == LATCHOFF_CYCLES - 12'h001)
					next_state = RUN_LATCHED;
				else
					next_count = count + 12'h001;
			RUN_LATCHED:
				next_state = RUN_LATCHED;
			default:
				next_state = RUN_OFF;
		endcase
		if (!enable)
		begin
			next_state = RUN_OFF;
			next_stage = 3'h0;
			next_count = 12'h000;
		end
	end

	// Setpoint codes
	genvar g;
	generate
		for (g = 0; g < NUM_PHASES; g++)
		begin : gen_gain
			assign gain_codes[g] = regs[int'(IDX_PHASE1_BALANCE_GAIN) + g][4:0];
		end
	endgenerate

	always_comb
	begin
		next_setpoint.gains  = gain_codes;
		next_setpoint.droop  = droop_code(regs[IDX_DROOP_SETTING][4:0],
			regs[IDX_DROOP_CALIBRATION][4:0]);
		next_setpoint.offset = offset_sum(regs[IDX_OUTPUT_OFFSET_TRIM][5:0],
			regs[IDX_OUTPUT_OFFSET_CAL][5:0]);
		// Either select bit alone keeps the pins in charge, so a half-done switch is harmless
		if (regs[IDX_REGULATOR_CONFIG_A][REGISTER_CODE_SELECT_BIT]
			&& regs[IDX_REGULATOR_CONFIG_B][REGISTER_CODE_SELECT_BIT])
			next_setpoint.voltage_id_code = regs[IDX_OUTPUT_VOLTAGE_CODE];
		else
			next_setpoint.voltage_id_code = vid_pins;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state                  <= RUN_OFF;
			startup_stage          <= 3'h0;
			count                  <= 12'h000;
			pending                <= 1'b0;
			phase_drive_enable     <= 1'b0;
			latched                <= 1'b0;
			secondary_limit_enable <= 1'b0;
			setpoint               <= '0;
			sda_out                <= 1'b0;
		end
		else
		begin
			state                  <= next_state;
			startup_stage          <= next_stage;
			count                  <= next_count;
			pending                <= next_pending;
			phase_drive_enable     <= next_state inside {RUN_STARTUP, RUN_NORMAL,
				RUN_LATCH_TIMER};
			latched                <= next_state == RUN_LATCHED;
			secondary_limit_enable <= next_state == RUN_STARTUP && output_below_200mv;
			setpoint               <= next_setpoint;
			sda_out                <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_last_stage_tick;
		state == RUN_STARTUP && startup_stage == STAGE_LAST
			&& count == STAGE_CYCLES - 12'h001 && enable;
	endsequence

	sequence s_trip_in_startup;
		state == RUN_STARTUP && current_limit_trip && enable;
	endsequence

	property p_run_trip;
		state == RUN_NORMAL && current_limit_trip && enable |=> state == RUN_LATCH_TIMER;
	endproperty
	a_run_trip: assert property (p_run_trip) else $error("trip in run did not start latchoff");

	property p_startup_continues;
		s_trip_in_startup ##0 (startup_stage != STAGE_LAST) ##1 enable |-> state == RUN_STARTUP;
	endproperty
	a_startup_continues: assert property (p_startup_continues) else $error("startup cut short");

	property p_startup_exit;
		s_last_stage_tick ##0 (pending || current_limit_trip) |=> state == RUN_LATCH_TIMER;
	endproperty
	a_startup_exit: assert property (p_startup_exit) else $error("remembered trip lost");

	property p_recover;
		state == RUN_LATCH_TIMER && !current_limit_trip && enable
			|=> state == RUN_NORMAL && phase_drive_enable;
	endproperty
	a_recover: assert property (p_recover) else $error("no return to normal");

	property p_latch_hold;
		state == RUN_LATCHED && enable |=> state == RUN_LATCHED && latched;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latchoff cleared early");

	property p_enable_low;
		!enable |=> state == RUN_OFF && !phase_drive_enable;
	endproperty
	a_enable_low: assert property (p_enable_low) else $error("enable low ignored");

	property p_clamp;
		secondary_limit_enable |-> state == RUN_STARTUP && $past(output_below_200mv);
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp outside startup");

	property p_timer;
		state == RUN_LATCH_TIMER && current_limit_trip && enable
			&& count == LATCHOFF_CYCLES - 12'h001 |=> state == RUN_LATCHED ##1 !phase_drive_enable;
	endproperty
	a_timer: assert property (p_timer) else $error("timer expiry missed");

	// Gated by the sampled reset so the release edge, where setpoint is still zero, is skipped
	property p_vid_select;
		rst_n && !(regs[IDX_REGULATOR_CONFIG_A][REGISTER_CODE_SELECT_BIT]
			&& regs[IDX_REGULATOR_CONFIG_B][REGISTER_CODE_SELECT_BIT])
			|=> setpoint.voltage_id_code == $past(vid_pins);
	endproperty
	a_vid_select: assert property (p_vid_select) else $error("register code used too soon");

	property p_offset_sat;
		setpoint.offset[4:0] <= OFFSET_LIMIT[4:0] && (setpoint.offset[4:0] != 5'h00
			|| !setpoint.offset[OFFSET_SIGN_BIT]);
	endproperty
	a_offset_sat: assert property (p_offset_sat) else $error("offset code malformed");
endmodule

// ---- vr_bus_host.sv ----
// Purpose: Two-wire bus controller acting as the system host
// Assumes: sda is the resolved wire level, pulled up when nobody pulls it low
// Notes:   Lines change on falling clk edges; scl phases last 3 to 5 clk
`timescale 1ns/1ps
module vr_bus_host
(
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_pull
);
	import vr_pkg::*;

	initial
	begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Data moves one clk after scl falls so it never reads as start or stop
	task automatic send_bit(input logic b, output logic seen);
		tick(1);
		sda_pull = !b;
		tick(2);
		scl = 1'b1;
		tick(2);
		seen = sda;
		tick(2);
		scl = 1'b0;
	endtask

	task automatic start_cond();
		tick(1);
		sda_pull = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(3);
		sda_pull = 1'b1;
		tick(2);
		scl = 1'b0;
	endtask

	task automatic stop_cond();
		tick(1);
		sda_pull = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(3);
		sda_pull = 1'b0;
		tick(2);
	endtask

	task automatic byte_out(input logic [7:0] v, inout logic ok);
		logic s;
		for (int i = 7; i >= 0; i--)
			send_bit(v[i], s);
		send_bit(1'b1, s);
		ok = ok & !s;
	endtask

	task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
		ok = 1'b1;
		start_cond();
		byte_out({TARGET_ADDRESS, 1'b0}, ok);
		byte_out(cmd, ok);
		byte_out(data, ok);
		stop_cond();
	endtask

	// Single byte read, ended by a not-acknowledge
	task automatic read_reg(input logic [7:0] cmd, output logic [7:0] v, output logic ok);
		logic s;
		ok = 1'b1;
		start_cond();
		byte_out({TARGET_ADDRESS, 1'b0}, ok);
		byte_out(cmd, ok);
		start_cond();
		byte_out({TARGET_ADDRESS, 1'b1}, ok);
		for (int i = 7; i >= 0; i--)
		begin
			send_bit(1'b1, s);
			v[i] = s;
		end
		send_bit(1'b1, s);
		stop_cond();
	endtask
endmodule

// ---- vr_setpoint_and_latchoff_tb.sv ----
// Purpose: Self-checking bench for setpoints and over-current latchoff
// Assumes: Host model drives the bus; bench drives pins on falling edges
// Notes:   Status byte low five bits hold the one-hot run state
`timescale 1ns/1ps
module vr_setpoint_and_latchoff_tb;
	import vr_pkg::*;
	logic         clk;
	logic         arst_n;
	logic         scl;
	logic         sda_pull;
	logic         sda_out;
	logic         sda_oe;
	logic         sda;
	logic         enable;
	logic         trip;
	logic         below;
	logic         drive;
	logic         latched;
	logic         sec_limit;
	logic [7:0]   vid_pins;
	logic [7:0]   v;
	logic [2:0]   stage;
	setpoint_type sp;
	int           failures;
	int           samples_checked;
	int           cycles;

	assign sda = !(sda_pull | sda_oe);

	vr_bus_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

	vr_setpoint_and_latchoff i_dut (.clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .enable(enable), .vid_pins(vid_pins),
		.current_limit_trip(trip), .output_below_200mv(below), .phase_drive_enable(drive),
		.latched(latched), .startup_stage(stage), .secondary_limit_enable(sec_limit),
		.setpoint(sp));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		logic ok;
		i_host.write_reg(cmd, data, ok);
		check_val("write ack", 8'h01, {7'h00, ok});
		tick(4);
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		logic ok;
		i_host.read_reg(cmd, v, ok);
		check_val("read ack", 8'h01, {7'h00, ok});
		check_val("read data", exp, v);
	endtask

	// Status reads return the value in v for the caller to judge
	task automatic rd_status();
		logic ok;
		i_host.read_reg(CMD_PROTECTION_STATUS, v, ok);
		check_val("status read ack", 8'h01, {7'h00, ok});
	endtask

	task automatic t_reset();
		check_val("vid out of reset", vid_pins, sp.voltage_id_code);
		check_val("droop out of reset", 8'h10, {3'h0, sp.droop});
		check_val("offset out of reset", 8'h00, {2'h0, sp.offset});
		check_val("sda_out level", 8'h00, {7'h00, sda_out});
		rd(CMD_OUTPUT_VOLTAGE_CODE, 8'h00);
		rd(CMD_REGULATOR_CONFIG_A, 8'h00);
		rd(CMD_REGULATOR_CONFIG_B, 8'h00);
		rd(CMD_OUTPUT_OFFSET_TRIM, 8'h00);
		rd(CMD_OUTPUT_OFFSET_CAL, 8'h00);
		rd(CMD_DROOP_CALIBRATION, 8'h10);
		rd(CMD_DROOP_SETTING, 8'h10);
		for (int i = 0; i < NUM_PHASES; i++)
		begin
			rd(CMD_PHASE1_BALANCE_GAIN + 8'(i), 8'h10);
			check_val("gain out of reset", 8'h10, {3'h0, sp.gains[i]});
		end
		rd(8'h50, 8'hFF);
	endtask

	task automatic t_droop();
		logic [23:0] tbl [6] = '{24'h10_00_00, 24'h10_1F_1F, 24'h10_10_10,
			24'h14_1F_1F, 24'h00_05_00, 24'h13_02_05};
		for (int i = 0; i < 6; i++)
		begin
			wr(CMD_DROOP_CALIBRATION, tbl[i][23:16]);
			wr(CMD_DROOP_SETTING, tbl[i][15:8]);
			check_val("droop code", tbl[i][7:0], {3'h0, sp.droop});
		end
	endtask

	task automatic t_balance();
		logic [7:0] codes [6] = '{8'h00, 8'h1F, 8'h10, 8'h01, 8'h1E, 8'h0F};
		for (int i = 0; i < NUM_PHASES; i++)
			wr(CMD_PHASE1_BALANCE_GAIN + 8'(i), codes[i]);
		for (int i = 0; i < NUM_PHASES; i++)
		begin
			check_val("phase gain", codes[i], {3'h0, sp.gains[i]});
			rd(CMD_PHASE1_BALANCE_GAIN + 8'(i), codes[i]);
		end
	endtask

	task automatic t_offset();
		logic [23:0] tbl [7] = '{24'h08_02_0A, 24'h21_2E_2F, 24'h0F_21_0E, 24'h1F_1F_1F,
			24'h3F_3F_3F, 24'h20_00_00, 24'h10_21_0F};
		for (int i = 0; i < 7; i++)
		begin
			wr(CMD_OUTPUT_OFFSET_TRIM, tbl[i][23:16]);
			wr(CMD_OUTPUT_OFFSET_CAL, tbl[i][15:8]);
			check_val("offset sum", tbl[i][7:0], {2'h0, sp.offset});
		end
	endtask

	task automatic t_vid_select();
		wr(CMD_OUTPUT_VOLTAGE_CODE, 8'hA5);
		wr(CMD_REGULATOR_CONFIG_A, 8'h08);
		check_val("vid one select", vid_pins, sp.voltage_id_code);
		wr(CMD_REGULATOR_CONFIG_B, 8'h08);
		check_val("vid both select", 8'hA5, sp.voltage_id_code);
		wr(CMD_REGULATOR_CONFIG_A, 8'h00);
		check_val("vid deselect", vid_pins, sp.voltage_id_code);
	endtask

	task automatic t_latch();
		int n;
		logic [2:0] last;
		below = 1'b1;
		trip = 1'b1;
		enable = 1'b1;
		tick(3);
		check_val("first stage", 8'h01, {5'h0, stage});
		check_val("startup clamp", 8'h01, {7'h0, sec_limit});
		below = 1'b0;
		tick(3);
		check_val("clamp release", 8'h00, {7'h0, sec_limit});
		last = stage;
		for (n = 0; n < 400 && stage != STAGE_LAST; n++)
		begin
			tick(1);
			if (stage != last)
				check_val("stage order", {5'h0, last} + 8'h01, {5'h0, stage});
			check_val("no early latch", 8'h00, {7'h0, latched});
			last = stage;
		end
		for (n = 0; n < 2300 && latched !== 1'b1; n++)
			tick(1);
		check_val("latch after stages", 8'h01, {7'h0, n >= 2048 && n <= 2150});
		check_val("latched drive", 8'h00, {7'h0, drive});
		trip = 1'b0;
		tick(50);
		check_val("latch holds", 8'h01, {7'h0, latched});
		check_val("drive stays off", 8'h00, {7'h0, drive});
		enable = 1'b0;
		tick(3);
		check_val("enable clears", 8'h00, {7'h0, latched});
		enable = 1'b1;
		tick(340);
		rd_status();
		check_val("normal state", 8'h04, {3'h0, v[4:0]});
		trip = 1'b1;
		tick(3);
		rd_status();
		check_val("timer state", 8'h08, {3'h0, v[4:0]});
		check_val("drive in timer", 8'h01, {7'h0, drive});
		trip = 1'b0;
		tick(3);
		rd_status();
		check_val("recovered state", 8'h04, {3'h0, v[4:0]});
		check_val("no latch", 8'h00, {7'h0, latched});
		trip = 1'b1;
		for (n = 0; n < 2200 && latched !== 1'b1; n++)
			tick(1);
		check_val("latch delay", 8'h01, {7'h0, n >= 2040 && n <= 2060});
		check_val("drive off", 8'h00, {7'h0, drive});
		arst_n = 1'b0;
		tick(2);
		check_val("power cycle clears", 8'h00, {7'h0, latched});
		arst_n = 1'b1;
		tick(4);
		check_val("restart after power", 8'h01, {7'h0, drive});
	endtask

	initial
	begin
		failures = 0;
		samples_checked = 0;
		cycles = 0;
		arst_n = 1'b0;
		enable = 1'b0;
		trip = 1'b0;
		below = 1'b0;
		vid_pins = 8'h3C;
		tick(5);
		arst_n = 1'b1;
		tick(4);
		t_reset();
		t_droop();
		t_balance();
		t_offset();
		t_vid_select();
		t_latch();
		tally_and_finish();
	end
endmodule
